// [rtl/sfv_pkg.sv]
package sfv_pkg;

    // Control map geometry and the indices that carry special meaning.
    localparam int REG_COUNT = 16;
    localparam int IDX_W = 4;
    localparam logic [3:0] IDX_CONFIG = 4'h0;
    localparam logic [3:0] IDX_RSVD_SIX = 4'h6;
    localparam logic [3:0] IDX_ENC_SAMPLE = 4'h9;
    localparam logic [3:0] IDX_RSVD_ELEVEN = 4'hB;
    localparam logic [3:0] IDX_RSVD_FOURTEEN = 4'hE;
    localparam logic [3:0] IDX_MASK_REV = 4'hF;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] RSVD_READ = 8'h00;
    localparam logic [3:0] MASK_REV_HIGH = 4'h0;

    // Fields of the configuration byte.
    localparam int CFG_DIG_PD_BIT = 0;
    localparam int CFG_MODE_LSB = 3;
    localparam int CFG_MODE_MSB = 4;
    localparam logic [1:0] IO_MODE_PCM = 2'h1;

    // Serial word lengths in bit clocks.
    localparam logic [3:0] ADPCM_BITS = 4'h4;
    localparam logic [3:0] PCM_BITS = 4'h8;
    localparam logic [3:0] NIBBLE_PAD = 4'h0;

    // Number of frame syncs the transmit output stays quiet after power-up.
    localparam logic [1:0] GUARD_SYNCS = 2'h2;

    // Control port frame: one header byte, then one data byte.
    localparam logic [4:0] CTL_HDR_BITS = 5'h08;
    localparam logic [4:0] CTL_FRAME_BITS = 5'h10;
    localparam int CTL_READ_BIT = 7;
    localparam int CTL_IDX_LSB = 3;

    typedef enum logic [1:0] {TX_IDLE, TX_ARMED, TX_SHIFT} sfv_tx_state_t;

endpackage : sfv_pkg

// [rtl/sfv_byte_regs.sv]
`timescale 1ns/1ps
`default_nettype none

// Sixteen-byte register store with one write port and a registered read.
module sfv_byte_regs
    import sfv_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic wr_en_in,
    input wire logic [IDX_W-1:0] wr_idx_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [IDX_W-1:0] rd_idx_in,
    output logic [7:0] rd_data_out
);

    logic [7:0] mem_ff [REG_COUNT];
    logic [7:0] rd_data_ff;

    // Storage cells; reset clears all so reads are defined from the start.
    generate
        for (genvar i = 0; i < REG_COUNT; i++)
        begin : g_cell
            always_ff @(posedge clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                    mem_ff[i] <= REG_RESET;
                else if (ce_in && wr_en_in && wr_idx_in == IDX_W'(i))
                    mem_ff[i] <= wr_data_in;
            end
        end
    endgenerate

    // Read data comes from a register, one cycle after the index.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rd_data_ff <= REG_RESET;
        else if (ce_in)
            rd_data_ff <= mem_ff[rd_idx_in];
    end

    assign rd_data_out = rd_data_ff;

endmodule : sfv_byte_regs
`default_nettype wire

// [rtl/sfv_voice_port.sv]
// Behaviour
// RQ1 - Short sync timing moves 4-bit ADPCM words, or 8-bit words in PCM codec mode.
// RQ2 - A sync seen high on exactly one transmit falling edge is short format.
// RQ3 - After a short sync, transmit drive starts on the next rising bit clock edge.
// RQ4 - Transmit output stays driven until mid least significant bit, then releases.
// RQ5 - Each frame sync decides how the following sync is handled.
// RQ6 - The far end changes sync format only across a power-down cycle.
// RQ7 - Transmit output stays released for two frame syncs after power-up or power-down.
// RQ8 - Receive uses the same sync and bit clock, latching our own word.
// RQ9 - Receive sync high on a falling edge captures the word on following falls.
// RQ10 - Receive counts bit clocks and moves the finished word to a holding register.
// RQ11 - Mode field bits 4:3 of the config byte selects full 8-bit PCM transfers.
// RQ12 - In 8-bit transfers bit four lasts a full period, bit eight half.
// RQ13 - Sixteen byte registers; indices six and eleven to fourteen are reserved.
// RQ14 - Index fifteen reports the mask revision in its low four bits.
// RQ15 - Writing one sets a control bit, writing zero clears it.
// RQ16 - A sync high across two consecutive transmit falling edges is long format.
// RQ17 - Serial words move most significant bit first in both directions.
`timescale 1ns/1ps
`default_nettype none

module sfv_voice_port
    import sfv_pkg::*;
#(
    parameter logic [3:0] MASK_REVISION = 4'h1  // Arbitrary value.
)
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic tx_bit_clock_in,
    input wire logic tx_frame_sync_in,
    input wire logic rx_bit_clock_in,
    input wire logic rx_frame_sync_in,
    input wire logic rx_serial_in_in,
    input wire logic [3:0] adpcm_tx_word_in,
    input wire logic ctl_clock_in,
    input wire logic ctl_enable_n_in,
    input wire logic ctl_data_in,
    output logic tx_serial_out_out,
    output logic tx_serial_oe_out,
    output logic [7:0] rx_word_out,
    output logic rx_word_valid_out,
    output logic [7:0] codec_config_out,
    output logic ctl_data_out,
    output logic ctl_data_oe_out
);

    // Local reset release through two flops; assertion stays asynchronous.
    logic rst_meta_ff, rst_n_ff;
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // All pins cross two flops; a third copy feeds the edge detectors only.
    localparam int PINS = 8;
    logic [PINS-1:0] pin_raw, pin_meta_ff, pin_sync_ff, pin_old_ff;
    assign pin_raw = {ctl_data_in, ctl_enable_n_in, ctl_clock_in, rx_serial_in_in,
                      rx_frame_sync_in, rx_bit_clock_in, tx_frame_sync_in, tx_bit_clock_in};
    always_ff @(posedge clk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
            pin_old_ff <= '0;
        end
        else if (ce_in)
        begin
            pin_meta_ff <= pin_raw;
            pin_sync_ff <= pin_meta_ff;
            pin_old_ff <= pin_sync_ff;
        end
    end

    // Named views of the synchronised pins and their edges.
    wire tx_fs = pin_sync_ff[1];
    wire rx_fs = pin_sync_ff[3];
    wire rx_din = pin_sync_ff[4];
    wire ctl_en_n = pin_sync_ff[6];
    wire ctl_din = pin_sync_ff[7];
    wire tx_rise = pin_sync_ff[0] && !pin_old_ff[0];
    wire tx_fall = !pin_sync_ff[0] && pin_old_ff[0];
    wire rx_fall = !pin_sync_ff[2] && pin_old_ff[2];
    wire ctl_rise = pin_sync_ff[5] && !pin_old_ff[5];
    wire ctl_fall = !pin_sync_ff[5] && pin_old_ff[5];

    // Shadow copies of the bytes that steer the datapath continuously.
    logic [7:0] cfg_ff, enc_sample_ff;
    wire [1:0] io_mode = cfg_ff[CFG_MODE_MSB:CFG_MODE_LSB];
    wire pcm_mode = (io_mode == IO_MODE_PCM);  // RQ11
    wire dig_pd = cfg_ff[CFG_DIG_PD_BIT];
    wire [3:0] word_len = pcm_mode ? PCM_BITS : ADPCM_BITS;  // RQ1

    // Sync levels at the last two falls; the tail of a long sync must not read as a short one.
    logic [1:0] fs_hist_ff;
    logic fmt_short_ff;
    wire sync_start = tx_fall && tx_fs && !fs_hist_ff[0];
    wire long_seen = tx_fall && tx_fs && fs_hist_ff[0];
    wire short_seen = tx_fall && !tx_fs && fs_hist_ff[0] && !fs_hist_ff[1];
    always_ff @(posedge clk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            fs_hist_ff <= '0;
            fmt_short_ff <= 1'b0;
        end
        else if (ce_in && tx_fall)
        begin
            fs_hist_ff <= {fs_hist_ff[0], tx_fs};
            if (long_seen)
                fmt_short_ff <= 1'b0;  // RQ16
            else if (short_seen)
                fmt_short_ff <= 1'b1;  // RQ2 RQ5
        end
    end

    // Power guard: counts sync starts since power-up or leaving power-down.
    // The count restarts while powered down so a far end that changed sync
    // format across the power-down cannot collide with us on the highway.
    logic [1:0] guard_ff;
    logic pd_old_ff;
    wire guard_done = (guard_ff == GUARD_SYNCS);
    always_ff @(posedge clk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            guard_ff <= '0;
            pd_old_ff <= 1'b0;
        end
        else if (ce_in)
        begin
            pd_old_ff <= dig_pd;
            if (dig_pd || pd_old_ff)
                guard_ff <= '0;  // RQ7 RQ6
            else if (sync_start && !guard_done)
                guard_ff <= guard_ff + 2'h1;  // RQ7
        end
    end

    // Transmit state machine.
    sfv_tx_state_t tx_state_ff, nxt_tx_state;
    logic [7:0] tx_shift_ff, nxt_tx_shift;
    logic [3:0] tx_cnt_ff, nxt_tx_cnt;
    logic tx_oe_ff, nxt_tx_oe;
    logic tx_bit_ff, nxt_tx_bit;
    wire [7:0] tx_load = pcm_mode ? enc_sample_ff : {adpcm_tx_word_in, NIBBLE_PAD};  // RQ1 RQ11
    wire tx_may_arm = fmt_short_ff && guard_done && !dig_pd;  // RQ5 RQ7

    always_comb
    begin
        nxt_tx_state = tx_state_ff;
        nxt_tx_shift = tx_shift_ff;
        nxt_tx_cnt = tx_cnt_ff;
        nxt_tx_oe = tx_oe_ff;
        nxt_tx_bit = tx_bit_ff;
        unique case (tx_state_ff)
            TX_IDLE:
            begin
                if (sync_start && tx_may_arm)
                    nxt_tx_state = TX_ARMED;  // RQ2
            end
            TX_ARMED:
            begin
                if (long_seen)
                    nxt_tx_state = TX_IDLE;  // RQ16
                else if (tx_rise)
                begin
                    // First bit leaves high impedance on this rising edge.
                    nxt_tx_oe = 1'b1;  // RQ3
                    nxt_tx_bit = tx_load[7];  // RQ17
                    nxt_tx_shift = {tx_load[6:0], 1'b0};
                    nxt_tx_cnt = 4'h1;
                    nxt_tx_state = TX_SHIFT;
                end
            end
            TX_SHIFT:
            begin
                if (tx_rise && tx_cnt_ff < word_len)
                begin
                    // Bit four in 8-bit mode simply lasts to the next rise.
                    nxt_tx_bit = tx_shift_ff[7];  // RQ12 RQ17
                    nxt_tx_shift = {tx_shift_ff[6:0], 1'b0};
                    nxt_tx_cnt = tx_cnt_ff + 4'h1;
                end
                else if (tx_fall && tx_cnt_ff == word_len)
                begin
                    // Mid last bit: release so the next talker can drive.
                    nxt_tx_oe = 1'b0;  // RQ4 RQ12
                    nxt_tx_state = TX_IDLE;
                end
            end
        endcase
        if (dig_pd)
        begin
            nxt_tx_oe = 1'b0;  // RQ7
            nxt_tx_state = TX_IDLE;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            tx_state_ff <= TX_IDLE;
            tx_shift_ff <= '0;
            tx_cnt_ff <= '0;
            tx_oe_ff <= 1'b0;
            tx_bit_ff <= 1'b0;
        end
        else if (ce_in)
        begin
            tx_state_ff <= nxt_tx_state;
            tx_shift_ff <= nxt_tx_shift;
            tx_cnt_ff <= nxt_tx_cnt;
            tx_oe_ff <= nxt_tx_oe;
            tx_bit_ff <= nxt_tx_bit;
        end
    end

    assign tx_serial_out_out = tx_bit_ff;
    assign tx_serial_oe_out = tx_oe_ff;

    // Receive capture; the same sync and clock as transmit work here, so
    // the device can read back its own word from the highway.
    logic rx_busy_ff;
    logic [3:0] rx_cnt_ff;
    logic [7:0] rx_shift_ff, rx_hold_ff;
    logic rx_valid_ff;
    wire [7:0] rx_next = {rx_shift_ff[6:0], rx_din};  // RQ17
    wire rx_last = (rx_cnt_ff + 4'h1 == word_len);
    always_ff @(posedge clk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            rx_busy_ff <= 1'b0;
            rx_cnt_ff <= '0;
            rx_shift_ff <= '0;
            rx_hold_ff <= '0;
            rx_valid_ff <= 1'b0;
        end
        else if (ce_in)
        begin
            rx_valid_ff <= 1'b0;
            if (rx_fall && !rx_busy_ff && rx_fs)
            begin
                rx_busy_ff <= 1'b1;  // RQ9 RQ8
                rx_cnt_ff <= '0;
            end
            else if (rx_fall && rx_busy_ff)
            begin
                rx_shift_ff <= rx_next;  // RQ9
                rx_cnt_ff <= rx_cnt_ff + 4'h1;  // RQ10
                if (rx_last)
                begin
                    rx_busy_ff <= 1'b0;
                    rx_hold_ff <= pcm_mode ? rx_next : {NIBBLE_PAD, rx_next[3:0]};  // RQ10 RQ11
                    rx_valid_ff <= 1'b1;
                end
            end
        end
    end

    assign rx_word_out = rx_hold_ff;
    assign rx_word_valid_out = rx_valid_ff;

    // Reserved indices hold nothing; used by both write and read paths.
    function automatic logic idx_defined(input logic [3:0] idx);
        idx_defined = (idx != IDX_RSVD_SIX) && !(idx >= IDX_RSVD_ELEVEN && idx <= IDX_RSVD_FOURTEEN)
                      && (idx != IDX_MASK_REV);
    endfunction : idx_defined

    // Control port: header byte (read flag, index), then one data byte.
    // Input is taken on rising control clocks, read data changes on falling.
    logic [4:0] ctl_cnt_ff;
    logic [7:0] ctl_hdr_ff, ctl_wdat_ff, ctl_out_ff;
    logic ctl_oe_ff;
    wire [3:0] ctl_idx = ctl_hdr_ff[CTL_IDX_LSB +: IDX_W];
    wire ctl_read = ctl_hdr_ff[CTL_READ_BIT];
    wire ctl_hdr_phase = (ctl_cnt_ff < CTL_HDR_BITS);
    wire ctl_wr_done = ctl_rise && !ctl_en_n && !ctl_read && (ctl_cnt_ff == CTL_FRAME_BITS - 5'h01);
    wire [7:0] ctl_wr_byte = {ctl_wdat_ff[6:0], ctl_din};  // RQ17
    wire reg_wr_en = ctl_wr_done && idx_defined(ctl_idx);  // RQ13 RQ14
    wire [7:0] mem_rd_data;
    wire [7:0] rd_byte = (ctl_idx == IDX_MASK_REV) ? {MASK_REV_HIGH, MASK_REVISION} :  // RQ14
                         idx_defined(ctl_idx) ? mem_rd_data : RSVD_READ;  // RQ13

    always_ff @(posedge clk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            ctl_cnt_ff <= '0;
            ctl_hdr_ff <= '0;
            ctl_wdat_ff <= '0;
            ctl_out_ff <= '0;
            ctl_oe_ff <= 1'b0;
        end
        else if (ce_in)
        begin
            if (ctl_en_n)
            begin
                ctl_cnt_ff <= '0;
                ctl_oe_ff <= 1'b0;
            end
            else
            begin
                if (ctl_rise && ctl_cnt_ff < CTL_FRAME_BITS)
                begin
                    ctl_cnt_ff <= ctl_cnt_ff + 5'h01;
                    if (ctl_hdr_phase)
                        ctl_hdr_ff <= {ctl_hdr_ff[6:0], ctl_din};  // RQ17
                    else
                        ctl_wdat_ff <= ctl_wr_byte;
                end
                if (ctl_fall && ctl_read && !ctl_hdr_phase)
                begin
                    // Read byte loads at the first fall after the header.
                    ctl_oe_ff <= (ctl_cnt_ff < CTL_FRAME_BITS);
                    ctl_out_ff <= (ctl_cnt_ff == CTL_HDR_BITS) ? rd_byte : {ctl_out_ff[6:0], 1'b0};  // RQ17
                end
            end
        end
    end

    assign ctl_data_out = ctl_out_ff[7];
    assign ctl_data_oe_out = ctl_oe_ff;

    // Shadow registers follow each accepted write; a one sets, zero clears.
    always_ff @(posedge clk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            cfg_ff <= REG_RESET;
            enc_sample_ff <= REG_RESET;
        end
        else if (ce_in && reg_wr_en)
        begin
            if (ctl_idx == IDX_CONFIG)
                cfg_ff <= ctl_wr_byte;  // RQ15 RQ11
            if (ctl_idx == IDX_ENC_SAMPLE)
                enc_sample_ff <= ctl_wr_byte;  // RQ15
        end
    end

    assign codec_config_out = cfg_ff;

    // Byte store for the whole map; reads settle long before the first fall.
    sfv_byte_regs i_sfv_byte_regs (
        .clk_in(clk_in),
        .rst_n_in(rst_n_ff),
        .ce_in(ce_in),
        .wr_en_in(reg_wr_en),
        .wr_idx_in(ctl_idx),
        .wr_data_in(ctl_wr_byte),
        .rd_idx_in(ctl_idx),
        .rd_data_out(mem_rd_data)
    );

endmodule : sfv_voice_port
`default_nettype wire

// [verification/sfv_voice_port_chk.sv]
`timescale 1ns/1ps
`default_nettype none

// Watches the transmit pins, the receive word and the control port of the voice port.
module sfv_voice_port_chk (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic tx_bit_clock_in,
    input wire logic tx_frame_sync_in,
    input wire logic tx_serial_out_out,
    input wire logic tx_serial_oe_out,
    input wire logic [7:0] rx_word_out,
    input wire logic rx_word_valid_out,
    input wire logic [7:0] codec_config_out,
    input wire logic ctl_enable_n_in,
    input wire logic ctl_data_oe_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    // Pins reach the logic a few cycles late, so each check leaves room for that lag.
    drive_on_rise_a: assert property ($rose(tx_serial_oe_out) |-> tx_bit_clock_in)
        else $error("transmit drive began while the bit clock was low");
    release_mid_bit_a: assert property ($fell(tx_serial_oe_out) |-> !tx_bit_clock_in)
        else $error("transmit drive ended outside the low half of a bit");
    drive_after_sync_a: assert property ($rose(tx_serial_oe_out) |-> $past(tx_frame_sync_in, 12))
        else $error("transmit drive began without a preceding sync");
    bits_on_rise_a: assert property (tx_serial_oe_out && $past(tx_serial_oe_out) && $changed(tx_serial_out_out)
        |-> tx_bit_clock_in)
        else $error("transmit bit changed while the bit clock was low");
    quiet_powered_down_a: assert property (codec_config_out[0] [*3] |-> !tx_serial_oe_out)
        else $error("transmit driven while powered down");
    valid_one_cycle_a: assert property (rx_word_valid_out |=> !rx_word_valid_out)
        else $error("receive valid lasted more than one cycle");
    word_with_valid_a: assert property ($changed(rx_word_out) |-> rx_word_valid_out)
        else $error("receive word changed without a valid pulse");
    config_by_port_a: assert property ($changed(codec_config_out) |-> !$past(ctl_enable_n_in, 2))
        else $error("configuration changed outside a control frame");
    ctl_idle_quiet_a: assert property (ctl_enable_n_in [*6] |-> !ctl_data_oe_out)
        else $error("control read data driven with the port idle");

    // Main scenarios reached by the bench.
    tx_word_c: cover property ($fell(tx_serial_oe_out));
    rx_word_c: cover property (rx_word_valid_out);
    ctl_read_c: cover property ($rose(ctl_data_oe_out));
endmodule : sfv_voice_port_chk

bind sfv_voice_port sfv_voice_port_chk i_sfv_voice_port_chk (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .tx_bit_clock_in(tx_bit_clock_in),
    .tx_frame_sync_in(tx_frame_sync_in),
    .tx_serial_out_out(tx_serial_out_out),
    .tx_serial_oe_out(tx_serial_oe_out),
    .rx_word_out(rx_word_out),
    .rx_word_valid_out(rx_word_valid_out),
    .codec_config_out(codec_config_out),
    .ctl_enable_n_in(ctl_enable_n_in),
    .ctl_data_oe_out(ctl_data_oe_out)
);

`default_nettype wire

// [verification/sfv_highway_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Highway switch: one bit clock and one sync feed both directions of the port.
module sfv_highway_model (
    input wire logic clk_in,
    input wire logic tx_data_in,
    input wire logic tx_oe_in,
    output logic bit_clock_out,
    output logic frame_sync_out,
    output logic rx_data_out
);
    logic [7:0] got_word;
    int got_bits;

    // The clock stands low between frames; an unread data line keeps toggling.
    initial
    begin
        bit_clock_out = 1'b0;
        frame_sync_out = 1'b0;
        rx_data_out = 1'b0;
        got_word = 8'h00;
        got_bits = 0;
    end

    // Half a bit clock of 160 ns, landing just after a system clock edge.
    task automatic half();
        repeat (8) @(posedge clk_in);
        #1;
    endtask : half

    // One bit period: sync and data change on the rise, transmit data is taken on the fall.
    task automatic cycle(input logic sync, input logic data);
        bit_clock_out = 1'b1;
        frame_sync_out = sync;
        rx_data_out = data;
        half();
        if (tx_oe_in === 1'b1)
        begin
            got_word = {got_word[6:0], tx_data_in};
            got_bits++;
        end
        bit_clock_out = 1'b0;
        half();
    endtask : cycle

    // A frame: quiet period, sync, the word MSB first, and one spare period to catch overrun.
    task automatic frame(input logic [7:0] word, input int nbits, input logic long_sync);
        got_word = 8'h00;
        got_bits = 0;
        cycle(1'b0, ~rx_data_out);
        cycle(1'b1, ~rx_data_out);
        if (long_sync)
            cycle(1'b1, ~rx_data_out);
        for (int i = 0; i < nbits; i++)
            cycle(1'b0, word[nbits - 1 - i]);
        cycle(1'b0, ~rx_data_out);
        rx_data_out = ~rx_data_out;
    endtask : frame
endmodule : sfv_highway_model

`default_nettype wire

// [verification/test_short_frame_sync_voice_port.sv]
`timescale 1ns/1ps
`default_nettype none

`define SFV_CHECK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module test_short_frame_sync_voice_port
    import sfv_pkg::*;
();
    localparam logic [3:0] MASK_REV = 4'h5;  // Arbitrary value.
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic ctl_clock = 1'b0;
    logic ctl_enable_n = 1'b1;
    logic ctl_din = 1'b0;
    logic bit_clock, frame_sync, rx_data, tx_data, tx_oe, rx_valid, ctl_dout, ctl_oe;
    logic [7:0] rx_word, cfg, rd;
    logic [7:0] pats [2] = '{8'hA5, 8'h5A};
    int miscompares = 0;
    int total_checks = 0;
    int valid_count = 0;

    // One shared clock and sync serve both directions; the receive word comes from the highway model, not from the port's transmit.
    sfv_voice_port #(.MASK_REVISION(MASK_REV)) i_sfv_voice_port (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1),
        .tx_bit_clock_in(bit_clock), .tx_frame_sync_in(frame_sync),
        .rx_bit_clock_in(bit_clock), .rx_frame_sync_in(frame_sync),
        .rx_serial_in_in(rx_data), .adpcm_tx_word_in(4'hB),
        .ctl_clock_in(ctl_clock), .ctl_enable_n_in(ctl_enable_n), .ctl_data_in(ctl_din),
        .tx_serial_out_out(tx_data), .tx_serial_oe_out(tx_oe),
        .rx_word_out(rx_word), .rx_word_valid_out(rx_valid), .codec_config_out(cfg),
        .ctl_data_out(ctl_dout), .ctl_data_oe_out(ctl_oe));

    sfv_highway_model i_sfv_highway_model (
        .clk_in(clk_in), .tx_data_in(tx_data), .tx_oe_in(tx_oe),
        .bit_clock_out(bit_clock), .frame_sync_out(frame_sync), .rx_data_out(rx_data));

    // System clock and a count of receive word pulses.
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in)
        if (rx_valid === 1'b1)
            valid_count++;

    // Reserved places read as zero and the top place shows only the revision.
    function automatic logic [7:0] exp_reg(input logic [3:0] idx, input logic [7:0] val);
        if (idx == IDX_MASK_REV)
            return {MASK_REV_HIGH, MASK_REV};
        if (idx == IDX_RSVD_SIX || (idx >= IDX_RSVD_ELEVEN && idx <= IDX_RSVD_FOURTEEN))
            return RSVD_READ;
        return val;
    endfunction : exp_reg

    task automatic half();
        repeat (8) @(posedge clk_in);
        #1;
    endtask : half

    // One control frame; read data is taken at each rising control clock.
    task automatic ctl_xfer(input logic read, input logic [3:0] idx, input logic [7:0] wdata);
        logic [15:0] bits;
        bits = {read, idx, 3'h0, wdata};
        ctl_enable_n = 1'b0;
        half();
        for (int i = 0; i < 16; i++)
        begin
            ctl_clock = 1'b0;
            ctl_din = bits[15 - i];
            half();
            ctl_clock = 1'b1;
            rd = {rd[6:0], ctl_dout};
            half();
        end
        ctl_clock = 1'b0;
        half();
        ctl_enable_n = 1'b1;
        ctl_din = ~ctl_din;
        half();
    endtask : ctl_xfer

    // A short-sync frame and the words seen in both directions.
    task automatic frame_check(input logic [7:0] rx_val, input int nbits, input int exp_bits,
                               input logic [7:0] exp_word);
        int vc;
        vc = valid_count;
        i_sfv_highway_model.frame(rx_val, nbits, 1'b0);
        `SFV_CHECK(i_sfv_highway_model.got_bits, exp_bits)
        if (exp_bits != 0)
            `SFV_CHECK(i_sfv_highway_model.got_word, exp_word)
        `SFV_CHECK(rx_word, rx_val)
        `SFV_CHECK(valid_count, vc + 1)
    endtask : frame_check

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // Register map first, then traffic in ADPCM, after power-down and in PCM mode.
    initial
    begin
        repeat (16) @(posedge clk_in);
        #1;
        reset_n_in = 1'b1;
        repeat (8) @(posedge clk_in);
        #1;
        for (int i = 0; i < 16; i++)
        begin
            ctl_xfer(1'b1, i[3:0], 8'h00);
            `SFV_CHECK(rd, exp_reg(i[3:0], 8'h00))
        end
        foreach (pats[p])
        begin
            for (int i = 1; i < 16; i++)
                ctl_xfer(1'b0, i[3:0], pats[p]);
            for (int i = 1; i < 16; i++)
            begin
                ctl_xfer(1'b1, i[3:0], 8'h00);
                `SFV_CHECK(rd, exp_reg(i[3:0], pats[p]))
            end
        end
        ctl_xfer(1'b0, IDX_CONFIG, 8'h18);
        `SFV_CHECK(cfg, 8'h18)
        ctl_xfer(1'b0, IDX_CONFIG, 8'h00);
        `SFV_CHECK(cfg, 8'h00)
        for (int f = 0; f < 3; f++)
            frame_check(8'h06, 4, (f == 2) ? 4 : 0, 8'h0B);
        // Long syncs after a power-down cycle; the third one passes the guard and still must not be served.
        ctl_xfer(1'b0, IDX_CONFIG, 8'h01);
        i_sfv_highway_model.frame(8'h00, 4, 1'b1);
        `SFV_CHECK(i_sfv_highway_model.got_bits, 0)
        ctl_xfer(1'b0, IDX_CONFIG, 8'h00);
        for (int f = 0; f < 3; f++)
        begin
            i_sfv_highway_model.frame(8'h00, 4, 1'b1);
            `SFV_CHECK(i_sfv_highway_model.got_bits, 0)
        end
        // Back to short syncs, again only across a power-down cycle.
        ctl_xfer(1'b0, IDX_CONFIG, 8'h01);
        ctl_xfer(1'b0, IDX_CONFIG, 8'h00);
        for (int f = 0; f < 3; f++)
            frame_check(8'h09, 4, (f == 2) ? 4 : 0, 8'h0B);
        ctl_xfer(1'b0, IDX_ENC_SAMPLE, 8'hC3);
        ctl_xfer(1'b0, IDX_CONFIG, 8'h08);
        frame_check(8'h5A, 8, 8, 8'hC3);
        ctl_xfer(1'b0, IDX_CONFIG, 8'h00);
        frame_check(8'h03, 4, 4, 8'h0B);
        test_done();
    end

    // The whole run needs about 25000 cycles; a hang is cut off well beyond that.
    initial
    begin
        repeat (80000) @(posedge clk_in);
        miscompares++;
        test_done();
    end
endmodule : test_short_frame_sync_voice_port

`default_nettype wire
